// ===== hw/pviu_pkg.sv
// Purpose: shared constants and types of the vectored interrupt unit
// Assumes: 8-bit registers except the 10-bit flags, 2-bit edge and 4-bit active, one per aligned Wishbone word
// Notes: sources are indexed in polling order, 0 polled first
package pviu_pkg;
  // ********************************
  // sources and polling order
  // ********************************
  localparam int PVIU_NSRC = 10;
  localparam int PVIU_SRC_EXT0 = 0;
  localparam int PVIU_SRC_TMR0 = 1;
  localparam int PVIU_SRC_EXT1 = 2;
  localparam int PVIU_SRC_TMR1 = 3;
  localparam int PVIU_SRC_SER0 = 4;
  localparam int PVIU_SRC_TMR2 = 6;
  // ********************************
  // register byte offsets
  // ********************************
  localparam logic [7:0] PVIU_OFS_EN_PRI = 8'h00;
  localparam logic [7:0] PVIU_OFS_EN_SEC = 8'h04;
  localparam logic [7:0] PVIU_OFS_PRIO_LO = 8'h08;
  localparam logic [7:0] PVIU_OFS_PRIO_HI = 8'h0C;
  localparam logic [7:0] PVIU_OFS_PRIO_SEC = 8'h10;
  localparam logic [7:0] PVIU_OFS_FLAGS = 8'h14;
  localparam logic [7:0] PVIU_OFS_EDGE = 8'h18;
  localparam logic [7:0] PVIU_OFS_ACTIVE = 8'h1C;
  // ********************************
  // field positions, masks, resets
  // ********************************
  localparam int PVIU_BIT_GLOBAL = 7;
  localparam int PVIU_BIT_SPI1_EN = 3;
  localparam int PVIU_BIT_SER2_EN = 2;
  localparam int PVIU_BIT_SER1_EN = 0;
  localparam logic [7:0] PVIU_MASK_EN_PRI = 8'hFF;
  localparam logic [7:0] PVIU_MASK_EN_SEC = 8'h0D;
  localparam logic [7:0] PVIU_MASK_PRIO = 8'h7F;
  localparam logic [7:0] PVIU_MASK_PRIO_SEC = 8'hF3;
  localparam logic [7:0] PVIU_RST_REG = 8'h00;
  localparam logic [9:0] PVIU_RST_FLAGS = 10'h000;
  localparam logic [3:0] PVIU_RST_ACTIVE = 4'h0;
  // ********************************
  // vector table, entry 9 listed first, entry 0 last
  // ********************************
  localparam logic [PVIU_NSRC-1:0][15:0] PVIU_VECTORS = {
    16'h0053, 16'h004B, 16'h003B, 16'h0033, 16'h002B,
    16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};
  // ********************************
  // types
  // ********************************
  typedef struct packed {
    logic found;
    logic [3:0] idx;
    logic [1:0] lvl;
  } pviu_pick_t;
  typedef enum logic [0:0] {PVIU_BUS_IDLE, PVIU_BUS_ACK} pviu_bus_t;
endpackage

// ===== hw/pviu_top.sv
// Purpose: prioritized vectored interrupt unit with Wishbone registers
// Assumes: core gives a state-2 strobe once per machine cycle
// Notes: all inputs are synchronous to CLK_IN
//
// Operation
// - ten sources, each with a two-bit level, larger is higher
// - per-source enables plus global enable at primary bit 7
// - primary enable bits: global, tmr2, spi0, ser0, tmr1, ext1, tmr0, ext0
// - secondary enable: spi1 bit 3, serial 2 bit 2, serial 1 bit 0
// - primary level is high-register bit over low-register bit
// - secondary levels: spi1 7:6, serial 2 5:4, serial 1 1:0
// - running service preempted only by strictly higher level
// - higher level wins; equal levels resolved by fixed polling order
// - flags captured each state 2, polled in the next machine cycle
// - call makes core push only pc and load the vector
// - call withheld while equal or higher active or not last cycle
// - call withheld during return or while the block input is high
// - external pin level or falling-edge triggered per select bit
// - external flag cleared on vectoring only in edge mode
// - external latency above 3 and below 7 machine cycles
// - timer 0/1 flags set on rollover, cleared on vectoring
// - serial request is rx or tx; serial and spi not cleared here
// - every request flag writable by software, one sets; zero clears flags 0-3 and only the software pend of 4-9
// - fixed vector per source, 0003H through 0053H
// - return releases the recorded active level
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module pviu_top import pviu_pkg::*; (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESETN_IN,
  // wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // core timing
  input wire logic MC_STATE2_IN,
  input wire logic INSTR_LAST_CYCLE_IN,
  input wire logic INSTR_BLOCK_IN,
  input wire logic RETURN_FROM_INTERRUPT_IN,
  // sources
  input wire logic EXT_IRQ_PIN0_IN,
  input wire logic EXT_IRQ_PIN1_IN,
  input wire logic TIMER0_OVERFLOW_IN,
  input wire logic TIMER1_OVERFLOW_IN,
  input wire logic TIMER2_REQ_IN,
  input wire logic [2:0] SERIAL_RX_FLAG_IN,
  input wire logic [2:0] SERIAL_TX_FLAG_IN,
  input wire logic [1:0] SPI_REQ_IN,
  // core call
  output logic CALL_REQ_OUT,
  output logic [15:0] VECTOR_OUT,
  output logic [3:0] ACTIVE_LEVELS_OUT,
  output logic TIMER2_VECTORED_OUT
);
  // ********************************
  // helpers
  // ********************************
  // highest eligible request; outer loop downward gives level first
  function automatic pviu_pick_t pick_src(input logic [9:0] r,
      input logic [9:0][1:0] lv, input logic [3:0] act);
    pviu_pick_t p;
    p = '0;
    for (int l = 3; l >= 0; l--) begin
      for (int s = 0; s < PVIU_NSRC; s++) begin
        if (!p.found && r[s] && lv[s] == 2'(l) &&
            (act >> l) == 4'h0) begin
          p.found = 1'b1;
          p.idx = 4'(s);
          p.lvl = 2'(l);
        end
      end
    end
    return p;
  endfunction

  // drop the highest active level
  function automatic logic [3:0] clr_top(input logic [3:0] act);
    logic [3:0] res;
    int top;
    res = act;
    top = 0;
    for (int s = 0; s < 4; s++) begin
      if (act[s]) begin
        top = s;
      end
    end
    res[top] = 1'b0;
    return res;
  endfunction

  // ********************************
  // state
  // ********************************
  logic [7:0] en_pri;
  logic [7:0] en_sec;
  logic [7:0] prio_lo;
  logic [7:0] prio_hi;
  logic [7:0] prio_sec;
  logic [1:0] edge_sel;
  logic [3:0] local_flag;
  logic [9:4] soft_pend;
  logic [9:0] sample;
  logic [3:0] active;
  logic [1:0] pin_prev;
  pviu_bus_t bus_state;
  logic [9:0] raw_req;
  logic [9:0] enabled;
  logic [9:0][1:0] level;
  pviu_pick_t pick;
  logic take;
  logic [9:0] take_hot;
  logic wr_lo;
  logic wr_hi;
  logic [1:0] ext_evt;
  logic [1:0] ext_clr;
  logic [31:0] next_rdata;

  // ********************************
  // enables and levels
  // ********************************
  // primary layout matches source order 0..6
  assign enabled[6:0] = en_pri[6:0];
  assign enabled[7] = en_sec[PVIU_BIT_SER1_EN];
  assign enabled[8] = en_sec[PVIU_BIT_SER2_EN];
  assign enabled[9] = en_sec[PVIU_BIT_SPI1_EN];

  // two bits per source
  always_comb begin
    for (int s = 0; s < 7; s++) begin
      level[s] = {prio_hi[s], prio_lo[s]};
    end
    level[7] = prio_sec[1:0];
    level[8] = prio_sec[5:4];
    level[9] = prio_sec[7:6];
  end

  // serial requests are rx or tx; software pend may raise any of 4-9
  assign raw_req[3:0] = local_flag;
  assign raw_req[4] = SERIAL_RX_FLAG_IN[0] | SERIAL_TX_FLAG_IN[0] |
                      soft_pend[4];
  assign raw_req[5] = SPI_REQ_IN[0] | soft_pend[5];
  assign raw_req[6] = TIMER2_REQ_IN | soft_pend[6];
  assign raw_req[7] = SERIAL_RX_FLAG_IN[1] | SERIAL_TX_FLAG_IN[1] |
                      soft_pend[7];
  assign raw_req[8] = SERIAL_RX_FLAG_IN[2] | SERIAL_TX_FLAG_IN[2] |
                      soft_pend[8];
  assign raw_req[9] = SPI_REQ_IN[1] | soft_pend[9];

  // ********************************
  // polling and call
  // ********************************
  // polls last machine cycle's sample at this state 2
  assign pick = pick_src(sample, level, active);
  assign take = MC_STATE2_IN & pick.found & INSTR_LAST_CYCLE_IN &
                ~INSTR_BLOCK_IN & ~RETURN_FROM_INTERRUPT_IN;
  assign take_hot = take ? (10'h001 << pick.idx) : 10'h000;

  // sample with enables and global gate; drop the one just taken
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      sample <= PVIU_RST_FLAGS;
    end else if (MC_STATE2_IN) begin
      sample <= raw_req & enabled & {10{en_pri[PVIU_BIT_GLOBAL]}} &
                ~take_hot;
    end
  end

  // call pulse with vector; core pushes only the pc
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      CALL_REQ_OUT <= 1'b0;
      VECTOR_OUT <= PVIU_VECTORS[0];
      TIMER2_VECTORED_OUT <= 1'b0;
    end else begin
      CALL_REQ_OUT <= take;
      TIMER2_VECTORED_OUT <= take_hot[PVIU_SRC_TMR2];
      if (take) begin
        VECTOR_OUT <= PVIU_VECTORS[pick.idx];
      end
    end
  end

  // active levels: return drops top, call sets its level
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      active <= PVIU_RST_ACTIVE;
    end else begin
      if (take) begin
        active <= active | (4'h1 << pick.lvl);
      end else if (RETURN_FROM_INTERRUPT_IN) begin
        active <= clr_top(active);
      end
    end
  end
  assign ACTIVE_LEVELS_OUT = active;

  // ********************************
  // local flags
  // ********************************
  // falling edge between two state-2 samples
  assign ext_evt[0] = MC_STATE2_IN & pin_prev[0] & ~EXT_IRQ_PIN0_IN;
  assign ext_evt[1] = MC_STATE2_IN & pin_prev[1] & ~EXT_IRQ_PIN1_IN;
  assign ext_clr[0] = take_hot[PVIU_SRC_EXT0] & edge_sel[0];
  assign ext_clr[1] = take_hot[PVIU_SRC_EXT1] & edge_sel[1];

  // pin history, one sample per machine cycle
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      pin_prev <= 2'b11;
    end else if (MC_STATE2_IN) begin
      pin_prev <= {EXT_IRQ_PIN1_IN, EXT_IRQ_PIN0_IN};
    end
  end

  // set beats clear so an event in the clear cycle survives
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      local_flag <= 4'h0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        if (!edge_sel[e] && MC_STATE2_IN) begin
          local_flag[2*e] <= ~pin_prev[e] | ~(e == 0 ?
              EXT_IRQ_PIN0_IN : EXT_IRQ_PIN1_IN) ? ~(e == 0 ?
              EXT_IRQ_PIN0_IN : EXT_IRQ_PIN1_IN) : 1'b0;
        end else if (ext_evt[e]) begin
          local_flag[2*e] <= 1'b1;
        end else if (ext_clr[e]) begin
          local_flag[2*e] <= 1'b0;
        end else if (wr_lo && WB_ADR_IN == PVIU_OFS_FLAGS) begin
          local_flag[2*e] <= WB_DAT_IN[2*e];
        end
      end
      if (TIMER0_OVERFLOW_IN) begin
        local_flag[PVIU_SRC_TMR0] <= 1'b1;
      end else if (take_hot[PVIU_SRC_TMR0]) begin
        local_flag[PVIU_SRC_TMR0] <= 1'b0;
      end else if (wr_lo && WB_ADR_IN == PVIU_OFS_FLAGS) begin
        local_flag[PVIU_SRC_TMR0] <= WB_DAT_IN[PVIU_SRC_TMR0];
      end
      if (TIMER1_OVERFLOW_IN) begin
        local_flag[PVIU_SRC_TMR1] <= 1'b1;
      end else if (take_hot[PVIU_SRC_TMR1]) begin
        local_flag[PVIU_SRC_TMR1] <= 1'b0;
      end else if (wr_lo && WB_ADR_IN == PVIU_OFS_FLAGS) begin
        local_flag[PVIU_SRC_TMR1] <= WB_DAT_IN[PVIU_SRC_TMR1];
      end
    end
  end

  // software pend bits; vectoring never clears them
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      soft_pend <= 6'h00;
    end else if (WB_ADR_IN == PVIU_OFS_FLAGS) begin
      if (wr_lo) begin
        soft_pend[7:4] <= WB_DAT_IN[7:4];
      end
      if (wr_hi) begin
        soft_pend[9:8] <= WB_DAT_IN[9:8];
      end
    end
  end

  // ********************************
  // wishbone slave
  // ********************************
  // write lands on the ack edge, when the master samples ack
  assign wr_lo = WB_CYC_IN & WB_STB_IN & WB_WE_IN & WB_ACK_OUT &
                 WB_SEL_IN[0];
  assign wr_hi = WB_CYC_IN & WB_STB_IN & WB_WE_IN & WB_ACK_OUT &
                 WB_SEL_IN[1];

  // configuration registers; reserved bits never stored
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      en_pri <= PVIU_RST_REG;
      en_sec <= PVIU_RST_REG;
      prio_lo <= PVIU_RST_REG;
      prio_hi <= PVIU_RST_REG;
      prio_sec <= PVIU_RST_REG;
      edge_sel <= 2'b00;
    end else if (wr_lo) begin
      if (WB_ADR_IN == PVIU_OFS_EN_PRI) begin
        en_pri <= WB_DAT_IN[7:0] & PVIU_MASK_EN_PRI;
      end else if (WB_ADR_IN == PVIU_OFS_EN_SEC) begin
        en_sec <= WB_DAT_IN[7:0] & PVIU_MASK_EN_SEC;
      end else if (WB_ADR_IN == PVIU_OFS_PRIO_LO) begin
        prio_lo <= WB_DAT_IN[7:0] & PVIU_MASK_PRIO;
      end else if (WB_ADR_IN == PVIU_OFS_PRIO_HI) begin
        prio_hi <= WB_DAT_IN[7:0] & PVIU_MASK_PRIO;
      end else if (WB_ADR_IN == PVIU_OFS_PRIO_SEC) begin
        prio_sec <= WB_DAT_IN[7:0] & PVIU_MASK_PRIO_SEC;
      end else if (WB_ADR_IN == PVIU_OFS_EDGE) begin
        edge_sel <= WB_DAT_IN[1:0];
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (WB_ADR_IN == PVIU_OFS_EN_PRI) begin
      next_rdata[7:0] = en_pri;
    end else if (WB_ADR_IN == PVIU_OFS_EN_SEC) begin
      next_rdata[7:0] = en_sec;
    end else if (WB_ADR_IN == PVIU_OFS_PRIO_LO) begin
      next_rdata[7:0] = prio_lo;
    end else if (WB_ADR_IN == PVIU_OFS_PRIO_HI) begin
      next_rdata[7:0] = prio_hi;
    end else if (WB_ADR_IN == PVIU_OFS_PRIO_SEC) begin
      next_rdata[7:0] = prio_sec;
    end else if (WB_ADR_IN == PVIU_OFS_FLAGS) begin
      next_rdata[9:0] = raw_req;
    end else if (WB_ADR_IN == PVIU_OFS_EDGE) begin
      next_rdata[1:0] = edge_sel;
    end else if (WB_ADR_IN == PVIU_OFS_ACTIVE) begin
      next_rdata[3:0] = active;
    end
  end

  // one wait state, ack held one cycle
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      bus_state <= PVIU_BUS_IDLE;
      WB_ACK_OUT <= 1'b0;
      WB_DAT_OUT <= 32'h0000_0000;
    end else begin
      case (bus_state)
        PVIU_BUS_IDLE: begin
          if (WB_CYC_IN && WB_STB_IN) begin
            bus_state <= PVIU_BUS_ACK;
            WB_ACK_OUT <= 1'b1;
            WB_DAT_OUT <= next_rdata;
          end
        end
        default: begin
          bus_state <= PVIU_BUS_IDLE;
          WB_ACK_OUT <= 1'b0;
        end
      endcase
    end
  end

  // ********************************
  // assertions
  // ********************************
  a_call_gated: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) CALL_REQ_OUT |-> $past(INSTR_LAST_CYCLE_IN)
    && !$past(INSTR_BLOCK_IN) && !$past(RETURN_FROM_INTERRUPT_IN))
    else $error("call outside last cycle or during block");
  a_vector_match: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) take |=> CALL_REQ_OUT &&
    VECTOR_OUT == PVIU_VECTORS[$past(pick.idx)])
    else $error("vector does not match chosen source");
  // the new level bit must outweigh every level already in service
  a_strict_preempt: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) CALL_REQ_OUT |-> $past(ACTIVE_LEVELS_OUT) <
    (ACTIVE_LEVELS_OUT ^ $past(ACTIVE_LEVELS_OUT)))
    else $error("preempted by equal or lower level");
  a_global_mask: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) MC_STATE2_IN && !en_pri[PVIU_BIT_GLOBAL]
    |=> sample == 10'h000)
    else $error("request sampled with global enable off");
  a_level_set: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) take |=> active[$past(pick.lvl)])
    else $error("active level not recorded");
  a_return_from_interrupt_release: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) RETURN_FROM_INTERRUPT_IN && !take
    |=> active == clr_top($past(active)))
    else $error("return did not release top level");
  a_edge_clear: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) ext_clr[0] && !ext_evt[0] |=> !local_flag[0])
    else $error("edge flag not cleared on vectoring");
  a_level_follow: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) MC_STATE2_IN && !edge_sel[0]
    |=> local_flag[0] == !$past(EXT_IRQ_PIN0_IN))
    else $error("level flag does not follow pin");
  a_timer_set: assert property (@(posedge CLK_IN)
    disable iff (!RESETN_IN) TIMER0_OVERFLOW_IN
    |=> local_flag[PVIU_SRC_TMR0])
    else $error("timer 0 overflow lost");
  a_ack_pulse: assert property (@(posedge CLK_IN) disable iff
    (!RESETN_IN) WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
endmodule

// ===== verif/pviu_core_model.sv
// Purpose: core-side model giving machine-cycle timing to the unit
// Assumes: three clocks per machine cycle, strobe in state 2
// Notes: stall and block requests come from the bench as levels
`timescale 1ns/100ps
module pviu_core_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // bench requests
  input wire logic stall_in,
  input wire logic block_in,
  // core timing to the unit
  output logic state2_out,
  output logic last_out,
  output logic block_out
);
  // ********************************
  // machine cycle sequencer
  // ********************************
  logic [1:0] phase;
  // outputs known before the first edge
  initial begin
    phase = 2'h0;
    state2_out = 1'b0;
    last_out = 1'b0;
    block_out = 1'b0;
  end
  // one state 2 strobe every third clock
  always @(posedge clk_in) begin
    if (!rstn_in || phase == 2'h2) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
    state2_out <= rstn_in && phase == 2'h0;
  end
  // instruction state, level between strobes
  always @(posedge clk_in) begin
    last_out <= !stall_in;
    block_out <= block_in;
  end
endmodule

// ===== verif/prioritized_vectored_interrupt_unit_test.sv
// Purpose: self-checking bench of the vectored interrupt unit
// Assumes: lfsr seed fixed, so every run is the same
// Notes: flags are raised by the source inputs and by software
`timescale 1ns/100ps
module prioritized_vectored_interrupt_unit_test import pviu_pkg::*;;
  // ********************************
  // stimulus and observed signals
  // ********************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dout;
  logic ack, call, t2v, st2, last, blko;
  logic return_from_interrupt = 1'b0, stall = 1'b0, blk = 1'b0, use_tx = 1'b0;
  logic [15:0] vec, r;
  logic [3:0] act;
  logic [9:0] src = 10'h000;
  logic [15:0] seed = 16'h0033;
  logic [7:0] lo, hi;
  logic [1:0] lv [10];
  logic [15:0] vtab [10] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
    16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h004B, 16'h0053};
  logic [7:0] msk [6] = '{PVIU_MASK_EN_PRI, PVIU_MASK_EN_SEC,
    PVIU_MASK_PRIO, PVIU_MASK_PRIO, PVIU_MASK_PRIO_SEC, 8'h00};
  int miscompares = 0, tests_run = 0, cycles = 0;
  int a, b, w, l;
  logic [2:0] ser;
  // pins are active low, serial ports use rx or tx by turn
  assign ser = {src[8], src[7], src[4]};
  always #5 clk = ~clk;
  pviu_top dut (.CLK_IN(clk), .RESETN_IN(rstn), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
    .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
    .MC_STATE2_IN(st2), .INSTR_LAST_CYCLE_IN(last),
    .INSTR_BLOCK_IN(blko), .RETURN_FROM_INTERRUPT_IN(return_from_interrupt), .EXT_IRQ_PIN0_IN(!src[0]),
    .EXT_IRQ_PIN1_IN(!src[2]), .TIMER0_OVERFLOW_IN(src[1]),
    .TIMER1_OVERFLOW_IN(src[3]), .TIMER2_REQ_IN(src[6]),
    .SERIAL_RX_FLAG_IN(use_tx ? 3'h0 : ser),
    .SERIAL_TX_FLAG_IN(use_tx ? ser : 3'h0),
    .SPI_REQ_IN({src[9], src[5]}), .CALL_REQ_OUT(call),
    .VECTOR_OUT(vec), .ACTIVE_LEVELS_OUT(act),
    .TIMER2_VECTORED_OUT(t2v));
  pviu_core_model core (.clk_in(clk), .rstn_in(rstn), .stall_in(stall),
    .block_in(blk), .state2_out(st2), .last_out(last),
    .block_out(blko));
  // ********************************
  // helpers
  // ********************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic next_rnd();
    seed = lfsr(seed);
    r = seed;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // classic cycle, released at the edge that samples ack
  task automatic wb(input logic w_in, input logic [7:0] a_in,
    input logic [31:0] d_in);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_in;
    adr <= a_in;
    wdat <= d_in;
    sel <= 4'hF;
    // ack and read data are taken at the rising edge that sees ack high;
    // only the hang guard ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic return_from_interrupt_pulse();
    @(posedge clk);
    return_from_interrupt <= 1'b1;
    @(posedge clk);
    return_from_interrupt <= 1'b0;
  endtask
  // no call may appear for n clocks
  task automatic quiet(input int n);
    int h;
    h = 0;
    repeat (n) begin
      @(negedge clk);
      if (call !== 1'b0) h++;
    end
    check(h, 0);
  endtask
  // bounded to seven machine cycles from the request
  task automatic expect_call(input int i, input int lvl);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (call !== 1'b1 && n < 21);
    check(call, 1);
    check(vec, vtab[i]);
    check(act, 4'h1 << lvl);
    check(t2v, i == 6);
  endtask
  function automatic int win(input int x, input int y);
    if (lv[x] != lv[y]) return (lv[x] > lv[y]) ? x : y;
    return (x < y) ? x : y;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, far above the planned run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // reset values, then masked write and read back
    for (int k = 0; k < 8; k++) begin
      wb(1'b0, 8'(k * 4), 32'h0);
      check(rdat, 32'h0);
    end
    // reserved bits written on purpose, they must stay zero
    repeat (4) begin
      for (int k = 0; k < 6; k++) begin
        next_rnd();
        wb(1'b1, (k == 5) ? 8'h20 : 8'(k * 4), {24'h0, r[7:0]});
        wb(1'b0, (k == 5) ? 8'h20 : 8'(k * 4), 32'h0);
        check(rdat, {24'h0, r[7:0] & msk[k]});
      end
    end
    for (int k = 0; k < 5; k++) wb(1'b1, 8'(k * 4), 32'h0);
    // each source from its own input, all at level 0
    wb(1'b1, PVIU_OFS_EDGE, 32'h3);
    wb(1'b1, PVIU_OFS_EN_PRI, 32'hFF);
    wb(1'b1, PVIU_OFS_EN_SEC, 32'h0D);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      use_tx <= i[0];
      src <= 10'h001 << i;
      if (i == 1 || i == 3) begin
        @(posedge clk);
        src <= 10'h000;
      end
      expect_call(i, 0);
      wb(1'b0, PVIU_OFS_FLAGS, 32'h0);
      check(rdat[i], i > 3);
      src <= 10'h000;
      quiet(12);
      return_from_interrupt_pulse();
      quiet(12);
      check(act, 0);
    end
    // level mode, flag follows the pin after the call
    wb(1'b1, PVIU_OFS_EDGE, 32'h0);
    @(posedge clk);
    src <= 10'h001;
    expect_call(0, 0);
    wb(1'b0, PVIU_OFS_FLAGS, 32'h0);
    check(rdat[0], 1);
    src <= 10'h000;
    quiet(12);
    return_from_interrupt_pulse();
    // random pairs of software requests with random levels
    wb(1'b1, PVIU_OFS_EDGE, 32'h3);
    for (int it = 0; it < 9; it++) begin
      next_rnd();
      a = r % 10;
      b = (a + 1 + (r >> 4) % 9) % 10;
      for (int s = 0; s < 10; s++) begin
        next_rnd();
        lv[s] = r[1:0];
      end
      for (int s = 0; s < 7; s++) begin
        lo[s] = lv[s][0];
        hi[s] = lv[s][1];
      end
      lo[7] = 1'b0;
      hi[7] = 1'b0;
      wb(1'b1, PVIU_OFS_PRIO_LO, {24'h0, lo});
      wb(1'b1, PVIU_OFS_PRIO_HI, {24'h0, hi});
      wb(1'b1, PVIU_OFS_PRIO_SEC, {24'h0, lv[9], lv[8], 2'h0, lv[7]});
      wb(1'b1, PVIU_OFS_EN_PRI, (it % 3 == 0) ? 32'h7F : 32'hFF);
      stall <= (it % 3 == 1);
      blk <= (it % 3 == 2);
      wb(1'b1, PVIU_OFS_FLAGS, (32'h1 << a) | (32'h1 << b));
      quiet(15);
      // release stall and block only after the enable write, or the
      // call could pulse while the bus cycle runs and be missed
      wb(1'b1, PVIU_OFS_EN_PRI, 32'hFF);
      stall <= 1'b0;
      blk <= 1'b0;
      w = win(a, b);
      l = (w == a) ? b : a;
      expect_call(w, lv[w]);
      quiet(15);
      wb(1'b1, PVIU_OFS_FLAGS, 32'h1 << l);
      quiet(9);
      return_from_interrupt_pulse();
      expect_call(l, lv[l]);
      wb(1'b1, PVIU_OFS_FLAGS, 32'h0);
      quiet(9);
      return_from_interrupt_pulse();
      quiet(9);
      check(act, 0);
    end
    stop_test();
  end
endmodule
